/* asf_pkg.sv */
// How it works
// [RULE1] transmit line rests at mark when idle
// [RULE2] one is mark high, zero is space low
// [RULE3] equal bits hold level, no neutral return
// [RULE4] one start bit, then eight or nine data
// [RULE5] start bit is space, stop bits mark
// [RULE6] frame ends with stop; extra idle allowed
// [RULE7] every bit lasts one baud period
// [RULE8] bit timing from 8/16-bit baud generator
// [RULE9] data bits travel least significant first
// [RULE10] independent transmitter and receiver, shared format
// [RULE11] no hardware parity; ninth bit carries it
// [RULE12] synchronous mode: receive and data share pin; the core has no synchronous transfer, both sides stay idle
// [RULE13] hardware switches shared line driver direction itself
// [RULE14] host synchronous: transmit and clock share pin; the core drives no clock, it only releases the pin driver
// [RULE15] receiver samples at sixteen times baud rate
// [RULE16] queued character loads right after stop bit
// [RULE17] ninth bit is most significant, sent last
// [RULE18] stop sampled at space flags framing error
package asf_pkg;

	// line levels
	localparam logic       LVL_MARK    = 1'h1;
	localparam logic       LVL_SPACE   = 1'h0;

	// oversampling: sixteen ticks per bit
	localparam logic [3:0] OS_LAST     = 4'hF;
	localparam logic [3:0] OS_MID      = 4'h7;
	localparam logic [3:0] OS_RESET    = 4'h0;

	// character lengths in data bits
	localparam logic [3:0] BITS_EIGHT  = 4'h8;
	localparam logic [3:0] BITS_NINE   = 4'h9;
	localparam logic [3:0] BIT_STEP    = 4'h1;

	// data widths and reset values
	localparam int         CHAR_W      = 9;
	localparam int         FIFO_DEPTH  = 32;
	localparam int         BRG_W       = 16;
	localparam logic [15:0] BRG_RESET  = 16'h0000;
	localparam logic [15:0] BRG_STEP   = 16'h0001;
	localparam logic [8:0] CHAR_RESET  = 9'h000;

	// transmitter states
	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_START = 2'b01,
		TX_DATA  = 2'b10,
		TX_STOP  = 2'b11
	} asf_tx_state_type;

	// receiver states
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} asf_rx_state_type;

endpackage

/* asf_fifo_if.sv */
// stream handshake between the core and its transmit queue
interface asf_fifo_if #(
	parameter int WIDTH = 9
);
	logic             in_valid;
	logic             in_ready;
	logic [WIDTH-1:0] in_data;
	logic             out_valid;
	logic             out_ready;
	logic [WIDTH-1:0] out_data;

	modport fifo (
		input  in_valid,
		output in_ready,
		input  in_data,
		output out_valid,
		input  out_ready,
		output out_data
	);

	modport user (
		output in_valid,
		input  in_ready,
		output in_data,
		input  out_valid,
		output out_ready,
		input  out_data
	);
endinterface

/* asf_fifo.sv */
module asf_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	asf_fifo_if.fifo  port
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] CNT_FULL = DEPTH[AW:0];

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr_ptr;
		logic [AW-1:0]               rd_ptr;
		logic [AW:0]                 count;
		logic                        ready;
	} asf_fifo_state_type;

	asf_fifo_state_type q;
	asf_fifo_state_type d;
	logic               push;
	logic               pop;

	// handshake views of the stored state
	assign port.in_ready  = q.ready;
	assign port.out_valid = (q.count != '0);
	assign port.out_data  = q.mem[q.rd_ptr];

	// next state; ready is registered so the writer sees a clean level
	always_comb begin
		d    = q;
		push = port.in_valid & q.ready;
		pop  = port.out_ready & (q.count != '0);
		if (push) begin
			d.mem[q.wr_ptr] = port.in_data;
			d.wr_ptr        = q.wr_ptr + 1'b1;
		end
		if (pop) begin
			d.rd_ptr = q.rd_ptr + 1'b1;
		end
		case ({push, pop})
			2'b10:   d.count = q.count + 1'b1;
			2'b01:   d.count = q.count - 1'b1;
			default: d.count = q.count;
		endcase
		d.ready = (d.count != CNT_FULL);
		if (!rst_n_i) begin
			d       = '0;
			d.ready = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		q <= d;
	end

	chk_fifo_no_overflow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		q.count <= CNT_FULL) else $error("queue count above depth");

endmodule // asf_fifo

/* asf_core.sv */
module asf_core (
	input  wire logic                       REF_CLK_I,
	input  wire logic                       RST_N_I,
	input  wire logic                       PORT_EN_I,
	input  wire logic                       SYNC_MODE_I,
	input  wire logic                       TX_EN_I,
	input  wire logic                       RX_EN_I,
	input  wire logic                       NINE_BIT_I,
	input  wire logic                       BRG16_I,
	input  wire logic [asf_pkg::BRG_W-1:0]  BAUD_DIV_I,
	input  wire logic [asf_pkg::CHAR_W-1:0] TX_DATA_I,
	input  wire logic                       TX_VALID_I,
	output logic                            TX_READY_O,
	output logic                            TX_BUSY_O,
	input  wire logic                       RECEIVE_DATA_LINE_I,
	output logic [asf_pkg::CHAR_W-1:0]      RX_DATA_O,
	output logic                            RX_VALID_O,
	output logic                            RX_FRAME_ERR_O,
	output logic                            TRANSMIT_CLOCK_LINE_O,
	output logic                            TRANSMIT_CLOCK_LINE_OE_O
);
	import asf_pkg::*;

	typedef struct packed {
		logic                  rx_meta;
		logic                  rx_sync;
		logic [BRG_W-1:0]      brg_cnt;
		logic                  tick;
		asf_tx_state_type      tx_st;
		logic [3:0]            tx_os;
		logic [3:0]            tx_cnt;
		logic [CHAR_W-1:0]     tx_shift;
		logic                  tx_line;
		logic                  tx_oe;
		logic                  tx_busy;
		asf_rx_state_type      rx_st;
		logic [3:0]            rx_os;
		logic [3:0]            rx_cnt;
		logic [CHAR_W-1:0]     rx_shift;
		logic [CHAR_W-1:0]     rx_data;
		logic                  rx_valid;
		logic                  rx_ferr;
	} asf_core_state_type;

	localparam asf_core_state_type ST_RST = '{
		rx_meta:  LVL_MARK,
		rx_sync:  LVL_MARK,
		brg_cnt:  BRG_RESET,
		tick:     1'b0,
		tx_st:    TX_IDLE,
		tx_os:    OS_RESET,
		tx_cnt:   4'h0,
		tx_shift: CHAR_RESET,
		tx_line:  LVL_MARK,
		tx_oe:    1'b0,
		tx_busy:  1'b0,
		rx_st:    RX_IDLE,
		rx_os:    OS_RESET,
		rx_cnt:   4'h0,
		rx_shift: CHAR_RESET,
		rx_data:  CHAR_RESET,
		rx_valid: 1'b0,
		rx_ferr:  1'b0
	};

	asf_core_state_type q;
	asf_core_state_type d;
	logic               async_on;
	logic [3:0]         nbits;
	logic [BRG_W-1:0]   brg_limit;
	logic               tx_take;

	asf_fifo_if #(.WIDTH(CHAR_W)) txq ();

	// transmit queue; its ready reaches the writer as back-pressure
	asf_fifo #(
		.WIDTH (CHAR_W),
		.DEPTH (FIFO_DEPTH)
	) u_txq (
		.clk_i   (REF_CLK_I),
		.rst_n_i (RST_N_I),
		.port    (txq.fifo)
	);

	assign txq.in_valid  = TX_VALID_I;
	assign txq.in_data   = TX_DATA_I;
	assign txq.out_ready = tx_take;

	// shared format and rate for both directions
	assign async_on  = PORT_EN_I & ~SYNC_MODE_I;
	assign nbits     = NINE_BIT_I ? BITS_NINE : BITS_EIGHT; // [RULE4] [RULE10]
	assign brg_limit = BRG16_I ? BAUD_DIV_I : {8'h00, BAUD_DIV_I[7:0]}; // [RULE8]

	// whole next state of the core
	always_comb begin
		d       = q;
		tx_take = 1'b0;

		// two-stage synchroniser on the receive pin
		d.rx_meta  = RECEIVE_DATA_LINE_I;
		d.rx_sync  = q.rx_meta;
		d.rx_valid = 1'b0;

		// one baud generator feeds both sides at sixteen ticks per bit
		d.tick = 1'b0;
		if (!PORT_EN_I) begin
			d.brg_cnt = BRG_RESET;
		end else if (q.brg_cnt >= brg_limit) begin // [RULE8]
			d.brg_cnt = BRG_RESET;
			d.tick    = 1'b1;
		end else begin
			d.brg_cnt = q.brg_cnt + BRG_STEP;
		end

		// transmitter: start, data lsb first, stop
		case (q.tx_st)
			TX_IDLE: begin
				d.tx_os = OS_RESET;
				if (async_on && TX_EN_I && txq.out_valid) begin
					tx_take    = 1'b1;
					d.tx_shift = txq.out_data;
					d.tx_cnt   = 4'h0;
					d.tx_st    = TX_START; // [RULE4]
				end
			end
			TX_START: begin
				if (q.tick) begin
					if (q.tx_os == OS_LAST) begin // [RULE7]
						d.tx_os = OS_RESET;
						d.tx_st = TX_DATA;
					end else begin
						d.tx_os = q.tx_os + BIT_STEP;
					end
				end
			end
			TX_DATA: begin
				if (q.tick) begin
					if (q.tx_os == OS_LAST) begin // [RULE7]
						d.tx_os    = OS_RESET;
						d.tx_shift = {1'b0, q.tx_shift[CHAR_W-1:1]}; // [RULE9] [RULE17]
						d.tx_cnt   = q.tx_cnt + BIT_STEP;
						if (q.tx_cnt == nbits - BIT_STEP) begin
							d.tx_st = TX_STOP; // [RULE6]
						end
					end else begin
						d.tx_os = q.tx_os + BIT_STEP;
					end
				end
			end
			TX_STOP: begin
				if (q.tick) begin
					if (q.tx_os == OS_LAST) begin
						d.tx_os = OS_RESET;
						// back to back: next character leaves without a gap
						if (async_on && TX_EN_I && txq.out_valid) begin // [RULE16]
							tx_take    = 1'b1;
							d.tx_shift = txq.out_data;
							d.tx_cnt   = 4'h0;
							d.tx_st    = TX_START;
						end else begin
							d.tx_st = TX_IDLE; // [RULE6]
						end
					end else begin
						d.tx_os = q.tx_os + BIT_STEP;
					end
				end
			end
			default: begin
				d.tx_st = TX_IDLE;
			end
		endcase

		// disabling the transmitter drops a character mid frame
		if (!async_on || !TX_EN_I) begin
			d.tx_st = TX_IDLE;
			tx_take = 1'b0;
		end

		// receiver: find start edge, confirm mid bit, sample bit centres
		case (q.rx_st)
			RX_IDLE: begin
				d.rx_os = OS_RESET;
				if (q.rx_sync == LVL_SPACE) begin
					d.rx_st = RX_START;
				end
			end
			RX_START: begin
				if (q.tick) begin
					if (q.rx_os == OS_MID) begin // [RULE15]
						d.rx_os  = OS_RESET;
						d.rx_cnt = 4'h0;
						// a glitch shorter than half a bit is no start
						d.rx_st  = (q.rx_sync == LVL_SPACE) ? RX_DATA : RX_IDLE;
					end else begin
						d.rx_os = q.rx_os + BIT_STEP;
					end
				end
			end
			RX_DATA: begin
				if (q.tick) begin
					if (q.rx_os == OS_LAST) begin // [RULE15]
						d.rx_os    = OS_RESET;
						d.rx_shift = {q.rx_sync, q.rx_shift[CHAR_W-1:1]}; // [RULE9] [RULE2]
						d.rx_cnt   = q.rx_cnt + BIT_STEP;
						if (q.rx_cnt == nbits - BIT_STEP) begin
							d.rx_st = RX_STOP;
						end
					end else begin
						d.rx_os = q.rx_os + BIT_STEP;
					end
				end
			end
			RX_STOP: begin
				if (q.tick && q.rx_os == OS_LAST) begin
					// ninth bit lands in the top position, passed through as is
					d.rx_data  = NINE_BIT_I ? q.rx_shift
						: {1'b0, q.rx_shift[CHAR_W-1:1]}; // [RULE11] [RULE17]
					d.rx_valid = 1'b1;
					d.rx_ferr  = (q.rx_sync == LVL_SPACE); // [RULE18]
					d.rx_os    = OS_RESET;
					d.rx_st    = RX_IDLE;
				end else if (q.tick) begin
					d.rx_os = q.rx_os + BIT_STEP;
				end
			end
			default: begin
				d.rx_st = RX_IDLE;
			end
		endcase

		// receiver stops on its own enable or when async mode is off, not on the transmitter's
		if (!async_on || !RX_EN_I) begin // [RULE10]
			d.rx_st = RX_IDLE;
		end

		// line level follows the next state so pin and state move together
		case (d.tx_st)
			TX_START: d.tx_line = LVL_SPACE; // [RULE5]
			TX_DATA:  d.tx_line = d.tx_shift[0]; // [RULE2] [RULE3]
			default:  d.tx_line = LVL_MARK; // [RULE1] [RULE5]
		endcase
		// driver direction handled here, never by software;
		// released in synchronous mode so the shared pin can carry clock
		d.tx_oe   = async_on; // [RULE13] [RULE14]
		d.tx_busy = (d.tx_st != TX_IDLE);

		if (!RST_N_I) begin
			d       = ST_RST;
			tx_take = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		q <= d;
	end

	// outputs straight from flops
	assign TX_READY_O               = txq.in_ready;
	assign TX_BUSY_O                = q.tx_busy;
	assign RX_DATA_O                = q.rx_data;
	assign RX_VALID_O               = q.rx_valid;
	assign RX_FRAME_ERR_O           = q.rx_ferr;
	assign TRANSMIT_CLOCK_LINE_O    = q.tx_line;
	assign TRANSMIT_CLOCK_LINE_OE_O = q.tx_oe;

	chk_idle_mark: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE1]
		q.tx_st == TX_IDLE |-> TRANSMIT_CLOCK_LINE_O == LVL_MARK)
		else $error("idle line not at mark");

	chk_start_space: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE5]
		q.tx_st == TX_START |-> TRANSMIT_CLOCK_LINE_O == LVL_SPACE)
		else $error("start bit not at space");

	chk_stop_mark: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE6]
		q.tx_st == TX_STOP |-> TRANSMIT_CLOCK_LINE_O == LVL_MARK)
		else $error("stop bit not at mark");

	chk_data_lsb: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE9]
		q.tx_st == TX_DATA |-> TRANSMIT_CLOCK_LINE_O == q.tx_shift[0])
		else $error("data bit does not follow lsb");

	chk_bit_length: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE7]
		(q.tx_st == TX_DATA && $past(q.tx_st) == TX_DATA && q.tx_cnt != $past(q.tx_cnt))
		|-> $past(q.tick && q.tx_os == OS_LAST))
		else $error("bit advanced before sixteen ticks");

	chk_data_count: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE4]
		q.tx_st == TX_DATA |-> q.tx_cnt < nbits)
		else $error("too many data bits");

	chk_fast_reload: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE16]
		(q.tx_st == TX_STOP && q.tick && q.tx_os == OS_LAST && txq.out_valid
		&& async_on && TX_EN_I) ##1 (async_on && TX_EN_I) |-> q.tx_st == TX_START)
		else $error("queued character not loaded after stop");

	chk_frame_error: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE18]
		(q.rx_st == RX_STOP && q.tick && q.rx_os == OS_LAST && q.rx_sync == LVL_SPACE
		&& async_on && RX_EN_I) |=> (RX_VALID_O && RX_FRAME_ERR_O))
		else $error("framing error not flagged");

	chk_oe_auto: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE13]
		SYNC_MODE_I |=> !TRANSMIT_CLOCK_LINE_OE_O)
		else $error("driver left on in synchronous mode");

endmodule // asf_core

/* asf_peer.sv */
// remote asynchronous transceiver facing the core's serial pins
module asf_peer (
	input  wire logic clk_i,
	input  wire logic line_i,
	output logic      line_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int         bit_clks = 16;
	logic       nine = 1'b0;
	logic [8:0] ch;
	logic [8:0] got_q[$];
	logic       stop_q[$];

	initial line_o = 1'b1;

	// one frame toward the core; a low stop level forces a framing fault
	task automatic send(input logic [8:0] c, input logic stop);
		int n;
		n = nine ? 9 : 8;
		line_o = 1'b0;
		repeat (bit_clks) @(negedge clk_i);
		for (int i = 0; i < n; i++) begin
			line_o = c[i];
			repeat (bit_clks) @(negedge clk_i);
		end
		line_o = stop;
		repeat (bit_clks) @(negedge clk_i);
		// a cut frame gets one idle bit at mark before the next start
		if (stop == 1'b0) begin
			line_o = 1'b1;
			repeat (bit_clks) @(negedge clk_i);
		end
	endtask

	// decode at mid bit, so a wrong bit length drifts into a wrong value
	initial forever begin
		@(negedge line_i);
		repeat (bit_clks / 2) @(posedge clk_i);
		ch = 9'h000;
		for (int i = 0; i < (nine ? 9 : 8); i++) begin
			repeat (bit_clks) @(posedge clk_i);
			ch[i] = line_i;
		end
		repeat (bit_clks) @(posedge clk_i);
		got_q.push_back(ch);
		stop_q.push_back(line_i);
	end
endmodule // asf_peer

/* asf_core_tb_top.sv */
module asf_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, port_en, sync_mode, tx_en, rx_en, nine, brg16, tx_valid;
	logic [15:0] baud_div;
	logic [8:0]  tx_data, rx_data;
	logic        tx_ready, tx_busy, rx_valid, rx_err, line, oe, peer_line;
	logic [8:0]  exp_q[$], rxx_q[$], rxd_q[$];
	logic        rxf_q[$], rxe_q[$];
	int          n_fail = 0;
	int          checked = 0;
	int          seed = 65744;

	asf_core u_asf_core (
		.REF_CLK_I(clk), .RST_N_I(rst_n), .PORT_EN_I(port_en), .SYNC_MODE_I(sync_mode),
		.TX_EN_I(tx_en), .RX_EN_I(rx_en), .NINE_BIT_I(nine), .BRG16_I(brg16),
		.BAUD_DIV_I(baud_div), .TX_DATA_I(tx_data), .TX_VALID_I(tx_valid),
		.TX_READY_O(tx_ready), .TX_BUSY_O(tx_busy), .RECEIVE_DATA_LINE_I(peer_line),
		.RX_DATA_O(rx_data), .RX_VALID_O(rx_valid), .RX_FRAME_ERR_O(rx_err),
		.TRANSMIT_CLOCK_LINE_O(line), .TRANSMIT_CLOCK_LINE_OE_O(oe)
	);
	asf_peer u_asf_peer (.clk_i(clk), .line_i(line), .line_o(peer_line));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic cmp_char(input string what, input logic [8:0] e, input logic [8:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic cmp_bit(input string what, input logic e, input logic g);
		cmp_char(what, {8'h00, e}, {8'h00, g});
	endtask

	// valid stays up between words so back to back writes need no gap
	task automatic put_tx(input logic [8:0] c);
		@(negedge clk);
		tx_valid = 1'b1;
		tx_data = c;
		exp_q.push_back(nine ? c : {1'b0, c[7:0]});
		do @(posedge clk); while (tx_ready !== 1'b1);
	endtask

	task automatic check_tx();
		int k;
		k = 0;
		while (u_asf_peer.got_q.size() < exp_q.size() && k < 8000) begin
			@(posedge clk);
			k++;
		end
		while (exp_q.size() > 0) begin
			cmp_char("tx char", exp_q.pop_front(), u_asf_peer.got_q.pop_front());
			cmp_bit("tx stop", 1'b1, u_asf_peer.stop_q.pop_front());
		end
	endtask

	task automatic rx_one(input logic [8:0] c, input logic stop);
		rxx_q.push_back(nine ? c : {1'b0, c[7:0]});
		rxf_q.push_back(~stop);
		u_asf_peer.send(c, stop);
	endtask

	task automatic check_rx();
		int k;
		k = 0;
		while (rxd_q.size() < rxx_q.size() && k < 2000) begin
			@(posedge clk);
			k++;
		end
		while (rxx_q.size() > 0) begin
			cmp_char("rx char", rxx_q.pop_front(), rxd_q.pop_front());
			cmp_bit("rx frame err", rxf_q.pop_front(), rxe_q.pop_front());
		end
	endtask

	// received characters are taken in the single cycle of the pulse
	always @(posedge clk) begin
		if (rx_valid === 1'b1) begin
			rxd_q.push_back(rx_data);
			rxe_q.push_back(rx_err);
		end
	end

	initial begin
		repeat (40000) @(posedge clk);
		n_fail++;
		tally_and_finish();
	end

	initial begin
		{rst_n, tx_valid, tx_en, sync_mode, nine, brg16} = 6'h00;
		{port_en, rx_en} = 2'h3;
		baud_div = 16'h0000;
		tx_data = 9'h000;
		repeat (2) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		repeat (2) @(negedge clk);
		cmp_bit("idle line", 1'b1, line);
		cmp_bit("driver on", 1'b1, oe);
		// in 8-bit divisor mode the upper byte must not slow the bit
		baud_div = {8'($random(seed)), 8'h00};
		repeat (32) put_tx(9'($random(seed)));
		@(negedge clk) tx_data = 9'($random(seed));
		repeat (3) @(posedge clk);
		cmp_bit("queue full", 1'b0, tx_ready);
		@(negedge clk) {tx_valid, tx_en} = 2'h1;
		check_tx();
		repeat (200) @(posedge clk);
		cmp_char("extra chars", 9'h000, 9'(u_asf_peer.got_q.size()));
		cmp_bit("idle busy", 1'b0, tx_busy);
		cmp_bit("idle after", 1'b1, line);
		// nine bits, both directions at once
		@(negedge clk) nine = 1'b1;
		u_asf_peer.nine = 1'b1;
		repeat (4) put_tx(9'($random(seed)));
		@(negedge clk) tx_valid = 1'b0;
		fork
			check_tx();
			repeat (4) rx_one(9'($random(seed)), 1'b1);
		join
		check_rx();
		// framing fault last, since a low stop may open a bogus frame
		@(negedge clk) nine = 1'b0;
		u_asf_peer.nine = 1'b0;
		rx_one(9'($random(seed)), 1'b1);
		rx_one(9'($random(seed)), 1'b0);
		check_rx();
		repeat (400) @(posedge clk);
		rxd_q.delete();
		rxe_q.delete();
		// 16-bit divisor of one gives 32 clocks per bit
		@(negedge clk) {brg16, baud_div} = {1'b1, 16'h0001};
		u_asf_peer.bit_clks = 32;
		repeat (2) put_tx(9'($random(seed)));
		@(negedge clk) tx_valid = 1'b0;
		cmp_bit("busy in frame", 1'b1, tx_busy);
		fork
			check_tx();
			repeat (2) rx_one(9'($random(seed)), 1'b1);
		join
		check_rx();
		// receiver off: a whole frame on the pin must yield nothing
		@(negedge clk) rx_en = 1'b0;
		u_asf_peer.send(9'($random(seed)), 1'b1);
		repeat (40) @(posedge clk);
		cmp_char("rx while off", 9'h000, 9'(rxd_q.size()));
		// synchronous mode releases the driver and sends nothing
		@(negedge clk) sync_mode = 1'b1;
		{tx_valid, tx_data} = {1'b1, 9'h0A5};
		@(negedge clk) tx_valid = 1'b0;
		repeat (100) @(negedge clk);
		cmp_bit("sync driver", 1'b0, oe);
		cmp_bit("sync busy", 1'b0, tx_busy);
		tally_and_finish();
	end
endmodule // asf_core_tb_top
